// file: design/bat_defs.svh
/*
 Register indices, field positions, reset values and timing counts of the
 biphase audio transmitter. Assumes byte address = 4 x index on the bus.
*/
`ifndef BAT_DEFS_SVH
`define BAT_DEFS_SVH

// -------------------------------------------------------------
// Register indices
// -------------------------------------------------------------
`define BAT_IDX_CTRL1      6'h00
`define BAT_IDX_RESV       6'h01
`define BAT_IDX_CTRL2      6'h02
`define BAT_IDX_TX         6'h03
`define BAT_IDX_CS0        6'h04
`define BAT_IDX_CS5        6'h09
`define BAT_IDX_ASSIGN     6'h0C
`define BAT_IDX_STATUS     6'h0D
`define BAT_IDX_PERIOD     6'h0E

// -------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------
`define BAT_C1_TIMING_RESET_N        0
`define BAT_C1_PW          1
`define BAT_C1_FMT         2
`define BAT_C2_SEL         0
`define BAT_C2_MODE        2
`define BAT_TX_TXE         0
`define BAT_TX_V           1
`define BAT_C1_FIXED       4'h8
`define BAT_RESV_VAL       8'h5B
`define BAT_TX_FIXED       6'h20
`define BAT_RST_FMT        2'h3
`define BAT_RST_SEL        2'h0
`define BAT_RST_CS         42'h00000000004

// -------------------------------------------------------------
// Timing counts
// -------------------------------------------------------------
`define BAT_INIT_BCLKS     4'h8
`define BAT_LAST_FRAME     8'hBF
`define BAT_CS_BITS        8'h2A
`define BAT_STATES_PER_FS  17'h00080
`define BAT_PERIOD_MAX     16'hFFFF

`endif

// file: design/bat_pkg.sv
/*
 Types of the biphase audio transmitter.
 Assumes bat_defs.svh supplies the numeric constants.
*/
package bat_pkg;

    typedef enum logic [1:0] {
        BAT_ST_HOLD,
        BAT_ST_INIT,
        BAT_ST_MEASURE,
        BAT_ST_RUN
    } bat_state_e;

    typedef enum logic [1:0] {
        BAT_PRE_B,
        BAT_PRE_M,
        BAT_PRE_W
    } bat_pre_e;

endpackage

// file: design/bat_top.sv
/*
 Biphase-mark audio transmitter: serial audio capture, block framing,
 biphase line coding and AXI4-Lite register file.
 Assumes REF_CLK is the master clock; audio pins are asynchronous.
*/
// Behaviour
// RQ1 - Run only after 8 bit clocks past release
// RQ2 - Controller pulses powerdown reset after power-up
// RQ3 - Master and channel clock share one source
// RQ4 - Listed master clock ratios and rates supported
// RQ5 - Ratio self-detected, no configuration needed
// RQ6 - MSB-first two's complement, rising bit clock
// RQ7 - Format select picks one of four formats
// RQ8 - Source zeroes low bits for 16-bit I2S
// RQ9 - No bit clock rise on channel edges
// RQ10 - Input select chooses serial input or bypass
// RQ11 - 192 frames, two sub-frames, 32 slots
// RQ12 - Biphase-mark coding of every data slot
// RQ13 - Block, channel-1, channel-2 preambles in slots 0-3
// RQ14 - Preamble patterns, complemented after high state
// RQ15 - Sample in slots 4-27, 16-bit zero-padded
// RQ16 - Slot 28 carries validity flag
// RQ17 - Slot 29 carries user data bit
// RQ18 - Slot 30 carries channel status bit
// RQ19 - Slot 31 gives even parity
// RQ20 - Frames back to back at fixed rate
// RQ21 - Left in channel 1, right in 2
// RQ22 - Consumer mode channel bits from assign control
// RQ23 - Line low in powerdown, reset, off, stopped
// RQ24 - 42-bit status buffer with its defaults
// RQ25 - Timing reset keeps configuration registers
// RQ26 - Unbuffered status and user bits sent zero
// RQ27 - Frame counter 0 to 191 wraps
`timescale 1ns/1ps
`include "bat_defs.svh"

module bat_top
    import bat_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        CE,
    input  wire logic        BIT_CLOCK_IN,
    input  wire logic        CHANNEL_CLOCK_IN,
    input  wire logic        SERIAL_INPUT_ONE,
    input  wire logic        SERIAL_INPUT_TWO,
    input  wire logic        POWERDOWN_RESET_N,
    output logic             TX_LINE_OUT,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // -------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------
    function automatic logic is_left(input logic [1:0] fmt, input logic lr);
        is_left = (fmt == 2'h3) ? ~lr : lr;
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx <= `BAT_IDX_CS5) || (idx == `BAT_IDX_ASSIGN)
              || (idx == `BAT_IDX_STATUS) || (idx == `BAT_IDX_PERIOD);
    endfunction

    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    logic [4:0] meta_reg;
    logic [4:0] sync_reg;
    logic       bclk_last_reg;
    logic       lr_last_reg;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            meta_reg      <= 5'h00;
            sync_reg      <= 5'h00;
            bclk_last_reg <= 1'b0;
            lr_last_reg   <= 1'b0;
        end else if (CE) begin
            meta_reg      <= {POWERDOWN_RESET_N, SERIAL_INPUT_TWO, SERIAL_INPUT_ONE,
                              CHANNEL_CLOCK_IN, BIT_CLOCK_IN};
            sync_reg      <= meta_reg;
            bclk_last_reg <= sync_reg[0];
            lr_last_reg   <= sync_reg[1];
        end
    end

    logic bclk_rise;
    logic lr_s;
    logic lr_rise;
    logic pdn_s;
    assign bclk_rise = sync_reg[0] & ~bclk_last_reg;
    assign lr_s      = sync_reg[1];
    assign lr_rise   = lr_s & ~lr_last_reg;
    assign pdn_s     = sync_reg[4];

    // -------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------
    logic        timing_reset_n_reg;
    logic        pw_reg;
    logic [1:0]  fmt_reg;
    logic        mode_reg;
    logic [1:0]  sel_reg;
    logic        v_reg;
    logic        txe_reg;
    logic [41:0] cs_reg;
    logic        assign_reg;
    logic        reg_clear;
    logic        wr_do;
    logic [5:0]  aw_idx_reg;
    logic [31:0] wdata_reg;
    logic        wstrb0_reg;

    assign reg_clear = RESET | ~pdn_s;

    always_ff @(posedge REF_CLK) begin
        if (reg_clear) begin
            timing_reset_n_reg   <= 1'b1;
            pw_reg     <= 1'b1;
            fmt_reg    <= `BAT_RST_FMT;
            mode_reg   <= 1'b0;
            sel_reg    <= `BAT_RST_SEL;
            v_reg      <= 1'b0;
            txe_reg    <= 1'b1;
            cs_reg     <= `BAT_RST_CS;              // [RQ24]
            assign_reg <= 1'b0;
        end else if (CE && wr_do && wstrb0_reg) begin
            unique case (aw_idx_reg)
                `BAT_IDX_CTRL1: begin
                    timing_reset_n_reg <= wdata_reg[`BAT_C1_TIMING_RESET_N];
                    pw_reg   <= wdata_reg[`BAT_C1_PW];
                    fmt_reg  <= wdata_reg[`BAT_C1_FMT +: 2];
                end
                `BAT_IDX_CTRL2: begin
                    sel_reg  <= wdata_reg[`BAT_C2_SEL +: 2];
                    mode_reg <= wdata_reg[`BAT_C2_MODE];
                end
                `BAT_IDX_TX: begin
                    txe_reg <= wdata_reg[`BAT_TX_TXE];
                    v_reg   <= wdata_reg[`BAT_TX_V];
                end
                `BAT_IDX_ASSIGN: assign_reg <= wdata_reg[0];
                6'h04, 6'h05, 6'h06, 6'h07, 6'h08:
                    cs_reg[8 * (aw_idx_reg - `BAT_IDX_CS0) +: 8] <= wdata_reg[7:0];
                `BAT_IDX_CS5: cs_reg[41:40] <= wdata_reg[1:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Timing sequencer
    // -------------------------------------------------------------
    bat_state_e  st_reg;
    logic        timing_clr;
    logic [3:0]  init_cnt_reg;
    logic [15:0] per_cnt_reg;
    logic [15:0] period_reg;
    logic        seen_reg;
    logic        per_ok_reg;

    assign timing_clr = reg_clear | ~timing_reset_n_reg | ~pw_reg;   // [RQ25]

    always_ff @(posedge REF_CLK) begin
        if (timing_clr) begin
            st_reg       <= BAT_ST_HOLD;
            init_cnt_reg <= 4'h0;
        end else if (CE) begin
            unique case (st_reg)
                BAT_ST_HOLD: st_reg <= BAT_ST_INIT;
                BAT_ST_INIT: if (bclk_rise) begin
                    init_cnt_reg <= init_cnt_reg + 4'h1;
                    if (init_cnt_reg == `BAT_INIT_BCLKS - 4'h1)
                        st_reg <= BAT_ST_MEASURE;                  // [RQ1]
                end
                BAT_ST_MEASURE: if (per_ok_reg) st_reg <= BAT_ST_RUN;
                BAT_ST_RUN: if (!per_ok_reg) st_reg <= BAT_ST_MEASURE;
            endcase
        end
    end

    // Channel clock period in master clocks sets the division
    always_ff @(posedge REF_CLK) begin
        if (timing_clr) begin
            per_cnt_reg <= 16'h0000;
            period_reg  <= 16'h0000;
            seen_reg    <= 1'b0;
            per_ok_reg  <= 1'b0;
        end else if (CE) begin
            if (lr_rise) begin
                per_cnt_reg <= 16'h0000;
                period_reg  <= per_cnt_reg + 16'h0001;                // [RQ4] [RQ5]
                seen_reg    <= 1'b1;
                per_ok_reg  <= seen_reg;
            end else if (per_cnt_reg == `BAT_PERIOD_MAX) begin
                seen_reg   <= 1'b0;
                per_ok_reg <= 1'b0;
            end else begin
                per_cnt_reg <= per_cnt_reg + 16'h0001;
            end
        end
    end

    // -------------------------------------------------------------
    // Serial audio capture
    // -------------------------------------------------------------
    logic        din;
    logic        lr_bit_reg;
    logic [5:0]  bit_cnt_reg;
    logic [23:0] sh_reg;
    logic [23:0] left_reg;
    logic [23:0] right_reg;
    logic        cap_now;
    logic        cap_chan;
    logic [23:0] cap_word;

    assign din = (mode_reg && sel_reg != 2'h0) ? sync_reg[3] : sync_reg[2];  // [RQ10]

    always_comb begin
        cap_now  = 1'b0;
        cap_chan = lr_bit_reg;
        cap_word = {sh_reg[22:0], din};
        if (lr_s != lr_bit_reg) begin
            cap_now = (fmt_reg[1] == 1'b0) || (fmt_reg == 2'h3 && bit_cnt_reg == 6'h0F);
            unique case (fmt_reg)
                2'h0: cap_word = {sh_reg[15:0], 8'h00};                    // [RQ15]
                2'h1: cap_word = sh_reg;
                default: cap_word = {sh_reg[14:0], din, 8'h00};
            endcase
        end else begin
            cap_now = (fmt_reg == 2'h2 && bit_cnt_reg == 6'h17)
                   || (fmt_reg == 2'h3 && bit_cnt_reg == 6'h18);           // [RQ7]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (timing_clr) begin
            lr_bit_reg  <= 1'b0;
            bit_cnt_reg <= 6'h00;
            sh_reg      <= 24'h000000;
            left_reg    <= 24'h000000;
            right_reg   <= 24'h000000;
        end else if (CE && bclk_rise) begin
            sh_reg     <= {sh_reg[22:0], din};                            // [RQ6]
            lr_bit_reg <= lr_s;
            if (lr_s != lr_bit_reg)
                bit_cnt_reg <= 6'h01;
            else if (bit_cnt_reg != 6'h3F)
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (cap_now && is_left(fmt_reg, cap_chan))
                left_reg <= cap_word;                                     // [RQ21]
            if (cap_now && !is_left(fmt_reg, cap_chan))
                right_reg <= cap_word;
        end
    end

    // -------------------------------------------------------------
    // Frame engine and biphase coder
    // -------------------------------------------------------------
    logic [16:0] acc_reg;
    logic [16:0] acc_sum;
    logic        strobe;
    logic        half_reg;
    logic [4:0]  slot_reg;
    logic        sub_reg;
    logic [7:0]  frame_reg;
    logic [31:0] word_reg;
    logic        line_reg;
    logic        prev_reg;
    logic        load;
    logic        cs_bit;
    logic [23:0] smp;
    logic [7:0]  pat;
    logic        pre_inv;
    bat_pre_e    pre;

    assign acc_sum = acc_reg + `BAT_STATES_PER_FS;
    assign strobe  = (st_reg == BAT_ST_RUN) && (acc_sum >= {1'b0, period_reg});
    assign load    = strobe && slot_reg == 5'h00 && !half_reg;
    assign smp     = sub_reg ? right_reg : left_reg;
    assign pre_inv = load ? line_reg : prev_reg;

    always_comb begin
        if (!sub_reg && frame_reg == 8'h00)
            pre = BAT_PRE_B;                                              // [RQ13]
        else if (!sub_reg)
            pre = BAT_PRE_M;
        else
            pre = BAT_PRE_W;
        unique case (pre)
            BAT_PRE_B: pat = 8'hE8;                                      // [RQ14]
            BAT_PRE_M: pat = 8'hE2;
            default:   pat = 8'hE4;
        endcase
        cs_bit = (frame_reg < `BAT_CS_BITS) ? cs_reg[frame_reg[5:0]] : 1'b0;  // [RQ26]
        if (!cs_reg[0] && frame_reg >= 8'h14 && frame_reg <= 8'h17)
            cs_bit = assign_reg && (frame_reg == (sub_reg ? 8'h15 : 8'h14));  // [RQ22]
    end

    always_ff @(posedge REF_CLK) begin
        if (timing_clr || st_reg != BAT_ST_RUN) begin
            acc_reg   <= 17'h00000;
            half_reg  <= 1'b0;
            slot_reg  <= 5'h00;
            sub_reg   <= 1'b0;
            frame_reg <= 8'h00;
            word_reg  <= 32'h00000000;
            line_reg  <= 1'b0;
            prev_reg  <= 1'b0;
        end else if (CE) begin
            acc_reg <= strobe ? acc_sum - {1'b0, period_reg} : acc_sum;   // [RQ20]
            if (strobe) begin
                half_reg <= ~half_reg;
                if (half_reg) begin
                    slot_reg <= slot_reg + 5'h01;
                    if (slot_reg == 5'h1F) begin
                        sub_reg <= ~sub_reg;                              // [RQ11]
                        if (sub_reg)
                            frame_reg <= (frame_reg == `BAT_LAST_FRAME) ? 8'h00
                                       : frame_reg + 8'h01;               // [RQ27]
                    end
                end
                if (load) begin
                    prev_reg <= line_reg;
                    word_reg <= {^{cs_bit, 1'b0, v_reg, smp},             // [RQ19]
                                 cs_bit, 1'b0, v_reg, smp, 4'h0};         // [RQ16] [RQ17] [RQ18]
                end
                if (slot_reg < 5'h04)
                    line_reg <= pat[3'h7 - {slot_reg[1:0], half_reg}] ^ pre_inv;
                else if (!half_reg)
                    line_reg <= ~line_reg;                                // [RQ12]
                else
                    line_reg <= line_reg ^ word_reg[slot_reg];
            end
        end
    end

    // Output gating and bypass path
    always_ff @(posedge REF_CLK) begin
        if (reg_clear) begin
            TX_LINE_OUT <= 1'b0;
        end else if (CE) begin
            if (!timing_reset_n_reg || !pw_reg || !txe_reg)
                TX_LINE_OUT <= 1'b0;                                      // [RQ23]
            else if (mode_reg && sel_reg == 2'h2)
                TX_LINE_OUT <= sync_reg[3];
            else if (mode_reg && sel_reg == 2'h3)
                TX_LINE_OUT <= 1'b0;
            else
                TX_LINE_OUT <= (st_reg == BAT_ST_RUN) && line_reg;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------
    logic aw_have_reg;
    logic w_have_reg;

    assign S_AXI_AWREADY = !aw_have_reg;
    assign S_AXI_WREADY  = !w_have_reg;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign wr_do         = aw_have_reg && w_have_reg && !S_AXI_BVALID;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_idx_reg   <= 6'h00;
            wdata_reg    <= 32'h00000000;
            wstrb0_reg   <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'h0;
        end else if (CE) begin
            if (S_AXI_AWVALID && !aw_have_reg) begin
                aw_have_reg <= 1'b1;
                aw_idx_reg  <= S_AXI_AWADDR[7:2];
            end
            if (S_AXI_WVALID && !w_have_reg) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA;
                wstrb0_reg <= S_AXI_WSTRB[0];
            end
            if (wr_do) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= mapped(aw_idx_reg) ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (S_AXI_ARADDR[7:2])
            `BAT_IDX_CTRL1:  rd_mux[7:0] = {`BAT_C1_FIXED, fmt_reg, pw_reg, timing_reset_n_reg};
            `BAT_IDX_RESV:   rd_mux[7:0] = `BAT_RESV_VAL;
            `BAT_IDX_CTRL2:  rd_mux[7:0] = {5'h00, mode_reg, sel_reg};
            `BAT_IDX_TX:     rd_mux[7:0] = {`BAT_TX_FIXED, v_reg, txe_reg};
            6'h04, 6'h05, 6'h06, 6'h07, 6'h08:
                rd_mux[7:0] = cs_reg[8 * (S_AXI_ARADDR[7:2] - `BAT_IDX_CS0) +: 8];
            `BAT_IDX_CS5:    rd_mux[1:0] = cs_reg[41:40];
            `BAT_IDX_ASSIGN: rd_mux[0] = assign_reg;
            `BAT_IDX_STATUS: rd_mux[10:0] = {st_reg, sub_reg, frame_reg};
            `BAT_IDX_PERIOD: rd_mux[15:0] = period_reg;
            default: ;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= 2'h0;
        end else if (CE) begin
            if (S_AXI_ARVALID && !S_AXI_RVALID) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_mux;
                S_AXI_RRESP  <= mapped(S_AXI_ARADDR[7:2]) ? 2'h0 : 2'h2;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    line_low_a: assert property (CE && !pdn_s |=> !TX_LINE_OUT)   // [RQ23]
        else $error("line not low in powerdown");
    init_eight_a: assert property ($past(st_reg) == BAT_ST_INIT
        && st_reg == BAT_ST_MEASURE |-> $past(init_cnt_reg) == 4'h7)   // [RQ1]
        else $error("init left early");
    biphase_edge_a: assert property (strobe && CE && !half_reg && slot_reg >= 5'h04
        && !timing_clr |=> line_reg != $past(line_reg))   // [RQ12]
        else $error("missing slot boundary transition");
    frame_wrap_a: assert property (strobe && CE && half_reg && slot_reg == 5'h1F && sub_reg
        && frame_reg == `BAT_LAST_FRAME && !timing_clr |=> frame_reg == 8'h00)   // [RQ27]
        else $error("frame counter did not wrap");
    even_parity_a: assert property (st_reg == BAT_ST_RUN && slot_reg >= 5'h04
        |-> ^word_reg[31:4] == 1'b0)   // [RQ19]
        else $error("odd parity in sub-frame");
    block_pre_a: assert property (strobe && CE && !sub_reg && frame_reg == 8'h00
        && slot_reg == 5'h02 && !half_reg && !timing_clr |=> line_reg == ~prev_reg)   // [RQ14]
        else $error("block preamble state wrong");
    chan_assign_a: assert property (load && CE && !cs_reg[0] && assign_reg && sub_reg
        && frame_reg == 8'h15 && !timing_clr |=> word_reg[30])   // [RQ22]
        else $error("right channel status bit missing");
    pad_zero_a: assert property (CE && bclk_rise && cap_now && fmt_reg == 2'h0
        && !timing_clr |=> ($past(cap_chan) ? left_reg[7:0] : right_reg[7:0]) == 8'h00)   // [RQ15]
        else $error("16-bit sample not zero padded");
    keep_config_a: assert property (!reg_clear && !timing_reset_n_reg && !wr_do
        |=> cs_reg == $past(cs_reg) && fmt_reg == $past(fmt_reg))   // [RQ25]
        else $error("timing reset touched configuration");

endmodule // bat_top

// file: bench/bat_src.sv
/*
 Audio source model: 24-bit I2S-style stereo, 64 bit clocks a sample.
 Assumes the bench raises run after the block's reset.
*/
`timescale 1ns/1ps
module bat_src (
    input  wire logic        run,
    input  wire logic [23:0] left,
    input  wire logic [23:0] right,
    output logic             bit_clk,
    output logic             chan_clk,
    output logic             sdata
);
    logic [5:0]  cnt;
    logic [23:0] smp;
    initial begin
        bit_clk = 1'b0;
        cnt     = 6'h00;
        #3;
        forever #32 bit_clk = run ? ~bit_clk : 1'b0;
    end
    // Channel clock and data move at falling edges only
    always @(negedge bit_clk) cnt <= cnt + 6'h01;
    assign chan_clk = cnt[5];
    assign smp      = cnt[5] ? right : left;
    // MSB first after a one-bit delay, then zeros
    assign sdata = (cnt[4:0] != 5'h00 && cnt[4:0] < 5'h19) ? smp[5'h18 - cnt[4:0]] : 1'b0;
endmodule // bat_src

// file: bench/test_bat_top.sv
/*
 Bench of the biphase audio transmitter: registers, framing, idle line.
 Assumes bat_src as audio source and a 125 MHz master clock.
*/
`timescale 1ns/1ps
`include "bat_defs.svh"
module test_bat_top;
    logic        clk = 1'b0, reset = 1'b1, pdn_n = 1'b0, run = 1'b0, watch = 1'b0, ce = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, line, bclk, chclk, sd, prev;
    logic [1:0]  bresp, rresp;
    int          n_errors, cmp_count, gap, longs, bad, highs;

    bat_src u_src (.run(run), .left(24'hA5C30F), .right(24'h1E2D3C),
        .bit_clk(bclk), .chan_clk(chclk), .sdata(sd));
    bat_top u_dut (.REF_CLK(clk), .RESET(reset), .CE(ce), .BIT_CLOCK_IN(bclk),
        .CHANNEL_CLOCK_IN(chclk), .SERIAL_INPUT_ONE(sd), .SERIAL_INPUT_TWO(sd),
        .POWERDOWN_RESET_N(pdn_n), .TX_LINE_OUT(line), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(1'b1));

    initial forever #4 clk = ~clk;
    // Line run lengths in master clocks
    always @(posedge clk) begin
        prev <= line;
        if (line === prev) gap <= gap + 1;
        else begin
            gap <= 1;
            if (watch && gap > 10 && gap < 14) longs <= longs + 1;
            if (watch && (gap % 4 == 2 || gap > 13)) bad <= bad + 1;
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        awaddr  <= {i, 2'h0};
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
        araddr  <= {i, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(i, d, r);
        chk(d, e);
    endtask
    task automatic quiet(input int n);
        highs = 0;
        repeat (4) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            if (line !== 1'b0) highs++;
        end
    endtask
    // -----------------------------------------------------
    // Scenarios
    // -----------------------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rc(`BAT_IDX_CTRL1, 32'h0000008F);
        rc(`BAT_IDX_TX, 32'h00000081);
        rc(`BAT_IDX_CS0, 32'h00000004);
        rc(`BAT_IDX_CS5, 32'h00000000);
        wr(`BAT_IDX_RESV, 8'h00);
        rc(`BAT_IDX_RESV, 32'h0000005B);
        rd(6'h0A, d, r);
        chk({30'h0, r}, 32'h00000002);
        chk(d, 32'h00000000);
        wr(6'h0A, 8'h00);
        chk({30'h0, bresp}, 32'h00000002);
    endtask
    task automatic t_run;
        logic [31:0] d;
        logic [1:0]  r;
        logic        h;
        int          n;
        run <= 1'b1;
        wr(`BAT_IDX_ASSIGN, 8'h01);
        rc(`BAT_IDX_ASSIGN, 32'h00000001);
        repeat (400) begin
            repeat (20) @(posedge clk);
            rd(`BAT_IDX_STATUS, d, r);
            if (d[10:9] === 2'h3) break;
        end
        chk({30'h0, d[10:9]}, 32'h00000003);
        repeat (300) @(posedge clk);
        watch <= 1'b1;
        repeat (1024) @(posedge clk);
        watch <= 1'b0;
        @(posedge clk);
        chk(longs, 6);
        chk(bad, 0);
        // Clock enable low freezes the line
        ce <= 1'b0;
        @(posedge clk);
        h = line;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (line !== h) n++;
        end
        ce <= 1'b1;
        chk(n, 0);
        // Format 0 capture, run on for 20 frames
        wr(`BAT_IDX_CTRL1, 8'h83);
        rc(`BAT_IDX_CTRL1, 32'h00000083);
        repeat (10240) @(posedge clk);
        wr(`BAT_IDX_CTRL1, 8'h8F);
    endtask
    task automatic t_idle;
        logic [5:0] ix [4] = '{`BAT_IDX_CTRL1, `BAT_IDX_CTRL1, `BAT_IDX_TX, `BAT_IDX_CTRL2};
        logic [7:0] vx [4] = '{8'h8E, 8'h8D, 8'h80, 8'h07};
        wr(`BAT_IDX_CS0, 8'h55);
        for (int k = 0; k < 4; k++) begin
            wr(ix[k], vx[k]);
            quiet(600);
            chk(highs, 0);
            wr(`BAT_IDX_CTRL1, 8'h8F);
            wr(`BAT_IDX_TX, 8'h81);
            wr(`BAT_IDX_CTRL2, 8'h00);
        end
        rc(`BAT_IDX_CS0, 32'h00000055);
        pdn_n <= 1'b0;
        quiet(600);
        chk(highs, 0);
        pdn_n <= 1'b1;
        repeat (8) @(posedge clk);
        rc(`BAT_IDX_CS0, 32'h00000004);
    endtask
    task automatic conclude;
        $display("checks=%0d errors=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        pdn_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_run();
        t_idle();
        conclude();
    end
endmodule // test_bat_top
